// ==== inc/smr_pkg.sv ====
// Package for the serial message recognizer: register map, field
// positions, reset values, timing counts and state encodings.
// Assumes a single 10 MHz system clock shared by all users.
`default_nettype none
package smr_pkg;
	// Clock and timing
	localparam int          CLK_HZ       = 10_000_000;
	localparam int          TICK_MS      = 1;
	localparam int          MS_CYCLES    = CLK_HZ / 1000 * TICK_MS;
	localparam int          BAUD_RATE    = 9600;
	localparam int          BAUD_CYCLES  = CLK_HZ / BAUD_RATE;
	// Storage sizes
	localparam int          BUF_BYTES    = 128;
	localparam int          TEXT_BYTES   = 12;
	localparam int          DELIM_BYTES  = 8;
	// Reset values and limits
	localparam logic [15:0] GAP_MIN_MS   = 16'h000A;
	localparam logic [15:0] GAP_RESET    = 16'h0000;
	localparam logic [7:0]  HOLD_RESET   = 8'h32;
	localparam logic [3:0]  DLEN_RESET   = 4'h0;
	localparam logic [63:0] DELIM_RESET  = 64'h0;
	// Register offsets (byte addresses)
	localparam logic [7:0]  ADDR_CTRL    = 8'h00;
	localparam logic [7:0]  ADDR_DLM_LO  = 8'h04;
	localparam logic [7:0]  ADDR_DLM_HI  = 8'h08;
	localparam logic [7:0]  ADDR_DLM_LEN = 8'h0C;
	localparam logic [7:0]  ADDR_GAP     = 8'h10;
	localparam logic [7:0]  ADDR_HOLD    = 8'h14;
	localparam logic [7:0]  ADDR_STATUS  = 8'h18;
	localparam logic [7:0]  ADDR_TX      = 8'h1C;
	localparam logic [7:0]  ADDR_DIGEST  = 8'h20;
	localparam logic [7:0]  ADDR_LTEXT   = 8'h40;
	localparam logic [7:0]  ADDR_LHEX    = 8'h60;
	localparam logic [7:0]  ADDR_TTEXT   = 8'h80;
	localparam logic [7:0]  ADDR_THEX    = 8'hA0;
	// Field positions
	localparam int          CTRL_MATCH   = 0;
	localparam int          CTRL_INJ     = 1;
	localparam int          CTRL_OP_LSB  = 2;
	localparam int          CTRL_CLEAR   = 4;
	localparam int          TX_MODE_LSB  = 8;
	// Encodings
	localparam logic [1:0]  OP_INJECT    = 2'h2;
	localparam logic [1:0]  TXM_ESC      = 2'h0;
	localparam logic [1:0]  TXM_RAW      = 2'h1;
	localparam logic [1:0]  TXM_HEX      = 2'h2;
	localparam logic [7:0]  ASCII_BSL    = 8'h5C;
	localparam logic [7:0]  ASCII_X      = 8'h78;

	typedef enum logic [3:0] {
		SMR_RX_IDLE  = 4'h1,
		SMR_RX_START = 4'h2,
		SMR_RX_DATA  = 4'h4,
		SMR_RX_STOP  = 4'h8
	} smr_rx_state_type;

	typedef enum logic [1:0] {
		SMR_TX_IDLE = 2'h1,
		SMR_TX_SEND = 2'h2
	} smr_tx_state_type;

	typedef enum logic [3:0] {
		SMR_ESC_PLAIN = 4'h1,
		SMR_ESC_SLASH = 4'h2,
		SMR_ESC_HI    = 4'h4,
		SMR_ESC_LO    = 4'h8
	} smr_esc_state_type;
endpackage
`default_nettype wire

// ==== verilog/smr_serial.sv ====
// Byte-level serial engine: 8N1 receiver and transmitter.
// Assumes the receive pin is asynchronous and a fixed bit period.
`default_nettype none
module smr_serial
	import smr_pkg::*;
#(
	parameter int BAUD_DIV = smr_pkg::BAUD_CYCLES
)
(
	// Clock and reset
	input  wire logic       clk,
	input  wire logic       arst_n,
	// Line
	input  wire logic       rxd_pin,
	output logic            txd,
	// Received bytes
	output logic            rx_valid,
	output logic [7:0]      rx_byte,
	// Bytes to send
	input  wire logic       tx_valid,
	input  wire logic [7:0] tx_byte,
	output logic            tx_ready
);
	localparam logic [15:0] BIT_LAST = 16'(BAUD_DIV - 1);
	localparam logic [15:0] BIT_HALF = 16'(BAUD_DIV / 2);

	typedef struct packed {
		logic [1:0]       sync;
		smr_rx_state_type rx_st;
		logic [15:0]      rx_cnt;
		logic [2:0]       rx_bit;
		logic [7:0]       rx_sh;
		logic             rx_valid;
		logic [7:0]       rx_byte;
		smr_tx_state_type tx_st;
		logic [15:0]      tx_cnt;
		logic [3:0]       tx_bit;
		logic [9:0]       tx_sh;
		logic             txd;
	} smr_serial_state_type;

	smr_serial_state_type r_reg;
	smr_serial_state_type r_next;
	logic                 line;

	// Only the second synchroniser stage is looked at
	assign line     = r_reg.sync[1];
	assign tx_ready = (r_reg.tx_st == SMR_TX_IDLE);
	assign txd      = r_reg.txd;
	assign rx_valid = r_reg.rx_valid;
	assign rx_byte  = r_reg.rx_byte;

	// Receive and transmit sequencing
	always_comb
	begin
		r_next          = r_reg;
		r_next.sync     = {r_reg.sync[0], rxd_pin};
		r_next.rx_valid = 1'b0;
		r_next.rx_cnt   = r_reg.rx_cnt + 16'h0001;
		case (r_reg.rx_st)
			SMR_RX_IDLE:
			begin
				r_next.rx_cnt = 16'h0000;
				if (!line)
					r_next.rx_st = SMR_RX_START;
			end
			SMR_RX_START:
				if (r_reg.rx_cnt == BIT_HALF)
				begin
					// Recentre on mid-bit; a glitch returns to idle
					r_next.rx_cnt = 16'h0000;
					r_next.rx_bit = 3'h0;
					r_next.rx_st  = line ? SMR_RX_IDLE : SMR_RX_DATA;
				end
			SMR_RX_DATA:
				if (r_reg.rx_cnt == BIT_LAST)
				begin
					r_next.rx_cnt = 16'h0000;
					r_next.rx_sh  = {line, r_reg.rx_sh[7:1]};
					r_next.rx_bit = r_reg.rx_bit + 3'h1;
					if (r_reg.rx_bit == 3'h7)
						r_next.rx_st = SMR_RX_STOP;
				end
			SMR_RX_STOP:
				if (r_reg.rx_cnt == BIT_LAST)
				begin
					// Framing errors drop the byte silently
					r_next.rx_valid = line;
					r_next.rx_byte  = r_reg.rx_sh;
					r_next.rx_st    = SMR_RX_IDLE;
				end
			default:
				r_next.rx_st = SMR_RX_IDLE;
		endcase
		case (r_reg.tx_st)
			SMR_TX_IDLE:
				if (tx_valid)
				begin
					r_next.tx_sh  = {1'b1, tx_byte, 1'b0};
					r_next.tx_cnt = 16'h0000;
					r_next.tx_bit = 4'h0;
					r_next.tx_st  = SMR_TX_SEND;
				end
			SMR_TX_SEND:
			begin
				r_next.tx_cnt = r_reg.tx_cnt + 16'h0001;
				if (r_reg.tx_cnt == BIT_LAST)
				begin
					r_next.tx_cnt = 16'h0000;
					r_next.tx_sh  = {1'b1, r_reg.tx_sh[9:1]};
					r_next.tx_bit = r_reg.tx_bit + 4'h1;
					if (r_reg.tx_bit == 4'h9)
						r_next.tx_st = SMR_TX_IDLE;
				end
			end
			default:
				r_next.tx_st = SMR_TX_IDLE;
		endcase
		r_next.txd = (r_next.tx_st == SMR_TX_SEND) ? r_next.tx_sh[0] : 1'b1;
	end

	// State register
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			r_reg       <= '0;
			r_reg.sync  <= 2'h3;
			r_reg.rx_st <= SMR_RX_IDLE;
			r_reg.tx_st <= SMR_TX_IDLE;
			r_reg.txd   <= 1'b1;
		end
		else
			r_reg <= r_next;
	end
endmodule // smr_serial
`default_nettype wire

// ==== verilog/smr_recognizer.sv ====
// Serial message recognizer top: register port, message buffer,
// delimiter and idle-gap recognition, result copies, send paths.
// Assumes a 10 MHz clock and a register master on the same clock.
`default_nettype none
module smr_recognizer
	import smr_pkg::*;
#(
	parameter int MS_DIV   = smr_pkg::MS_CYCLES,
	parameter int BAUD_DIV = smr_pkg::BAUD_CYCLES
)
(
	// Clock and reset
	input  wire logic        CLK,
	input  wire logic        ARST_N,
	// Register port
	input  wire logic [7:0]  REG_ADDR,
	input  wire logic [31:0] REG_WDATA,
	input  wire logic        REG_WR,
	input  wire logic        REG_RD,
	output logic [31:0]      REG_RDATA,
	// Serial line
	input  wire logic        SER_RXD,
	output logic             SER_TXD,
	// Events
	output logic             MSG_RECOGNIZED,
	output logic             MSG_TEXT_CHANGED
);
	localparam logic [15:0] MS_LAST = 16'(MS_DIV - 1);

	typedef struct packed {
		logic                           match_en;
		logic                           inj_en;
		logic [1:0]                     op_sel;
		logic [63:0]                    delim;
		logic [3:0]                     delim_len;
		logic [15:0]                    gap;
		logic [7:0]                     hold;
		logic [BUF_BYTES-1:0][7:0]      buffer;
		logic [7:0]                     count;
		logic [63:0]                    hist;
		logic [15:0]                    idle_ms;
		logic [7:0]                     dig_run;
		logic [TEXT_BYTES-1:0][7:0]     l_text;
		logic [7:0]                     l_len;
		logic [7:0]                     l_dig;
		logic                           l_valid;
		logic [TEXT_BYTES-1:0][7:0]     t_text;
		logic [7:0]                     t_dig;
		logic                           t_valid;
		logic [7:0]                     t_ms;
		logic [15:0]                    ms_div;
		smr_esc_state_type              esc;
		logic [3:0]                     nib;
		logic                           tx_valid;
		logic [7:0]                     tx_byte;
		logic [31:0]                    rdata;
		logic                           recog;
		logic                           changed;
	} smr_top_state_type;

	smr_top_state_type r_reg;
	smr_top_state_type r_next;
	logic              rx_valid;
	logic [7:0]        rx_byte;
	logic              tx_ready;
	logic              inj_state;

	// Nibble to upper-case hex character
	function automatic logic [7:0] to_asc(input logic [3:0] v);
		to_asc = (v < 4'hA) ? (8'h30 + {4'h0, v}) : (8'h37 + {4'h0, v});
	endfunction

	// Hex character to {valid, nibble}; either letter case accepted
	function automatic logic [4:0] from_asc(input logic [7:0] c);
		from_asc = 5'h00;
		if (c >= 8'h30 && c <= 8'h39)
			from_asc = {1'b1, 4'(c - 8'h30)};
		else if (c >= 8'h41 && c <= 8'h46)
			from_asc = {1'b1, 4'(c - 8'h37)};
		else if (c >= 8'h61 && c <= 8'h66)
			from_asc = {1'b1, 4'(c - 8'h57)};
	endfunction

	// Two text bytes rendered as four hex characters, first char low
	function automatic logic [31:0] hex_word(
		input logic [TEXT_BYTES-1:0][7:0] t, input logic [2:0] i);
		logic [7:0] a;
		logic [7:0] b;
		a = t[{i, 1'b0}];
		b = t[{i, 1'b1}];
		hex_word = {to_asc(b[3:0]), to_asc(b[7:4]),
			to_asc(a[3:0]), to_asc(a[7:4])};
	endfunction

	smr_serial #(
		.BAUD_DIV (BAUD_DIV)
	) u_serial (
		.clk      (CLK),
		.arst_n   (ARST_N),
		.rxd_pin  (SER_RXD),
		.txd      (SER_TXD),
		.rx_valid (rx_valid),
		.rx_byte  (rx_byte),
		.tx_valid (r_reg.tx_valid),
		.tx_byte  (r_reg.tx_byte),
		.tx_ready (tx_ready)
	);

	// Injection condition is derived, never written directly
	assign inj_state        = r_reg.inj_en && (r_reg.op_sel == OP_INJECT);
	assign REG_RDATA        = r_reg.rdata;
	assign MSG_RECOGNIZED   = r_reg.recog;
	assign MSG_TEXT_CHANGED = r_reg.changed;

	// Whole next-state computation
	always_comb
	begin
		logic                       tick;
		logic                       take;
		logic                       clr;
		logic                       hit;
		logic                       gap_hit;
		logic [63:0]                mask;
		logic [4:0]                 hv;
		logic [7:0]                 ch;
		logic [TEXT_BYTES-1:0][7:0] txt;
		tick    = 1'b0;
		take    = 1'b0;
		clr     = 1'b0;
		hit     = 1'b0;
		gap_hit = 1'b0;
		mask    = 64'h0;
		hv      = 5'h00;
		ch      = REG_WDATA[7:0];
		txt     = '0;
		r_next         = r_reg;
		r_next.rdata   = 32'h0;
		r_next.recog   = 1'b0;
		r_next.changed = 1'b0;
		tick           = (r_reg.ms_div == MS_LAST);
		r_next.ms_div  = tick ? 16'h0000 : r_reg.ms_div + 16'h0001;
		if (r_reg.tx_valid && tx_ready)
			r_next.tx_valid = 1'b0;

		// Register writes
		if (REG_WR)
		begin
			if (REG_ADDR == ADDR_CTRL)
			begin
				r_next.match_en = REG_WDATA[CTRL_MATCH];
				r_next.inj_en   = REG_WDATA[CTRL_INJ];
				r_next.op_sel   = REG_WDATA[CTRL_OP_LSB +: 2];
				clr             = REG_WDATA[CTRL_CLEAR];
			end
			else if (REG_ADDR == ADDR_DLM_LO)
				r_next.delim[31:0] = REG_WDATA;
			else if (REG_ADDR == ADDR_DLM_HI)
				r_next.delim[63:32] = REG_WDATA;
			else if (REG_ADDR == ADDR_DLM_LEN)
			begin
				if (REG_WDATA[3:0] <= 4'(DELIM_BYTES))
					r_next.delim_len = REG_WDATA[3:0];
			end
			else if (REG_ADDR == ADDR_GAP)
			begin
				// Values 1..9 are refused, old value kept
				if (REG_WDATA[15:0] == 16'h0000 || REG_WDATA[15:0] >= GAP_MIN_MS)
					r_next.gap = REG_WDATA[15:0];
			end
			else if (REG_ADDR == ADDR_HOLD)
				r_next.hold = REG_WDATA[7:0];
			else if (REG_ADDR == ADDR_TX && !r_reg.tx_valid)
			begin
				// One character per write; busy writes are dropped
				case (REG_WDATA[TX_MODE_LSB +: 2])
					TXM_RAW:
					begin
						r_next.tx_byte  = ch;
						r_next.tx_valid = 1'b1;
					end
					TXM_HEX:
					begin
						hv = from_asc(ch);
						if (hv[4] && r_reg.esc == SMR_ESC_LO)
						begin
							r_next.tx_byte  = {r_reg.nib, hv[3:0]};
							r_next.tx_valid = 1'b1;
							r_next.esc      = SMR_ESC_PLAIN;
						end
						else if (hv[4])
						begin
							r_next.nib = hv[3:0];
							r_next.esc = SMR_ESC_LO;
						end
					end
					default:
					begin
						hv = from_asc(ch);
						case (r_reg.esc)
							SMR_ESC_SLASH:
								if (ch == ASCII_X)
									r_next.esc = SMR_ESC_HI;
								else
								begin
									r_next.tx_byte  = ch;
									r_next.tx_valid = 1'b1;
									r_next.esc      = SMR_ESC_PLAIN;
								end
							SMR_ESC_HI:
							begin
								r_next.nib = hv[3:0];
								r_next.esc = hv[4] ? SMR_ESC_LO : SMR_ESC_PLAIN;
							end
							SMR_ESC_LO:
							begin
								r_next.tx_byte  = {r_reg.nib, hv[3:0]};
								r_next.tx_valid = hv[4];
								r_next.esc      = SMR_ESC_PLAIN;
							end
							default:
								if (ch == ASCII_BSL)
									r_next.esc = SMR_ESC_SLASH;
								else
								begin
									r_next.tx_byte  = ch;
									r_next.tx_valid = 1'b1;
								end
						endcase
					end
				endcase
			end
		end

		// Register reads, answered in the following cycle
		if (REG_RD)
		begin
			if (REG_ADDR == ADDR_CTRL)
				r_next.rdata = {27'h0, 1'b0, r_reg.op_sel, r_reg.inj_en,
					r_reg.match_en};
			else if (REG_ADDR == ADDR_DLM_LO)
				r_next.rdata = r_reg.delim[31:0];
			else if (REG_ADDR == ADDR_DLM_HI)
				r_next.rdata = r_reg.delim[63:32];
			else if (REG_ADDR == ADDR_DLM_LEN)
				r_next.rdata = {28'h0, r_reg.delim_len};
			else if (REG_ADDR == ADDR_GAP)
				r_next.rdata = {16'h0, r_reg.gap};
			else if (REG_ADDR == ADDR_HOLD)
				r_next.rdata = {24'h0, r_reg.hold};
			else if (REG_ADDR == ADDR_STATUS)
				r_next.rdata = {8'h0, r_reg.l_len, r_reg.count, 4'h0,
					!r_reg.tx_valid, inj_state, r_reg.t_valid, r_reg.l_valid};
			else if (REG_ADDR == ADDR_DIGEST)
				r_next.rdata = {16'h0, r_reg.t_dig, r_reg.l_dig};
			else if (REG_ADDR[7:4] == ADDR_LTEXT[7:4] && REG_ADDR[3:2] != 2'h3
				&& REG_ADDR[1:0] == 2'h0)
				r_next.rdata = r_reg.l_text[{REG_ADDR[3:2], 2'h0} +: 4];
			else if (REG_ADDR[7:5] == ADDR_LHEX[7:5] && REG_ADDR[4:2] < 3'h6
				&& REG_ADDR[1:0] == 2'h0)
				r_next.rdata = hex_word(r_reg.l_text, REG_ADDR[4:2]);
			else if (REG_ADDR[7:4] == ADDR_TTEXT[7:4] && REG_ADDR[3:2] != 2'h3
				&& REG_ADDR[1:0] == 2'h0)
				r_next.rdata = r_reg.t_text[{REG_ADDR[3:2], 2'h0} +: 4];
			else if (REG_ADDR[7:5] == ADDR_THEX[7:5] && REG_ADDR[4:2] < 3'h6
				&& REG_ADDR[1:0] == 2'h0)
				r_next.rdata = hex_word(r_reg.t_text, REG_ADDR[4:2]);
		end

		// Incoming bytes; a full buffer drops data but still watches
		take = rx_valid && r_reg.match_en;
		if (take)
		begin
			if (r_reg.count < 8'(BUF_BYTES))
			begin
				r_next.buffer[r_reg.count[6:0]] = rx_byte;
				r_next.count   = r_reg.count + 8'h01;
				r_next.dig_run = r_reg.dig_run ^ rx_byte;
			end
			r_next.hist    = {r_reg.hist[55:0], rx_byte};
			r_next.idle_ms = 16'h0000;
			for (int i = 0; i < DELIM_BYTES; i++)
				if (i < int'(r_reg.delim_len))
					mask[8*i +: 8] = 8'hFF;
			hit = (r_reg.delim_len != 4'h0)
				&& (((r_next.hist ^ r_reg.delim) & mask) == 64'h0);
		end
		else if (tick && r_reg.idle_ms != 16'hFFFF)
			r_next.idle_ms = r_reg.idle_ms + 16'h0001;
		// Counter keeps running, so a gap set later still fires
		gap_hit = !take && r_reg.gap != 16'h0000 && r_reg.count != 8'h00
			&& r_reg.idle_ms >= r_reg.gap;

		// Transient copies expire after the hold time
		if (r_reg.t_valid && tick)
		begin
			if (r_reg.t_ms >= r_reg.hold)
			begin
				r_next.t_valid = 1'b0;
				r_next.t_text  = '0;
				r_next.t_dig   = 8'h00;
			end
			else
				r_next.t_ms = r_reg.t_ms + 8'h01;
		end

		// Clear goes first so a recognition in the same cycle survives
		if (clr)
		begin
			r_next.l_text  = '0;
			r_next.l_len   = 8'h00;
			r_next.l_dig   = 8'h00;
			r_next.l_valid = 1'b0;
			r_next.t_text  = '0;
			r_next.t_dig   = 8'h00;
			r_next.t_valid = 1'b0;
		end

		// Publish the pending message to both copies
		if (hit || gap_hit)
		begin
			for (int i = 0; i < TEXT_BYTES; i++)
				if (i < int'(r_next.count))
					txt[i] = r_next.buffer[i];
			r_next.changed = (txt != r_next.l_text)
				|| (r_next.count != r_next.l_len);
			r_next.l_text  = txt;
			r_next.l_len   = r_next.count;
			r_next.l_dig   = r_next.dig_run;
			r_next.l_valid = 1'b1;
			r_next.t_text  = txt;
			r_next.t_dig   = r_next.dig_run;
			r_next.t_valid = 1'b1;
			r_next.t_ms    = 8'h00;
			r_next.count   = 8'h00;
			r_next.dig_run = 8'h00;
			r_next.hist    = 64'h0;
			r_next.recog   = 1'b1;
		end
	end

	// State register
	always_ff @(posedge CLK or negedge ARST_N)
	begin
		if (!ARST_N)
		begin
			r_reg           <= '0;
			r_reg.delim     <= DELIM_RESET;
			r_reg.delim_len <= DLEN_RESET;
			r_reg.gap       <= GAP_RESET;
			r_reg.hold      <= HOLD_RESET;
			r_reg.esc       <= SMR_ESC_PLAIN;
		end
		else
			r_reg <= r_next;
	end

	default clocking cb @(posedge CLK); endclocking
	default disable iff (!ARST_N);

	sequence seq_gap_refused;
		REG_WR && REG_ADDR == ADDR_GAP && REG_WDATA[15:0] != 16'h0000
			&& REG_WDATA[15:0] < GAP_MIN_MS;
	endsequence
	sequence seq_single_delim;
		rx_valid && r_reg.match_en && r_reg.delim_len == 4'h1
			&& rx_byte == r_reg.delim[7:0];
	endsequence

	AST_DISABLED_IGNORES: assert property (
		(rx_valid && !r_reg.match_en && !MSG_RECOGNIZED) |=>
			r_reg.count == $past(r_reg.count) || MSG_RECOGNIZED)
		else $error("byte taken while matching disabled");
	AST_DELIM_FIRES: assert property (
		seq_single_delim |=> MSG_RECOGNIZED ##1 r_reg.count == 8'h00)
		else $error("delimiter did not recognize");
	AST_GAP_FIRES: assert property (
		(!rx_valid && r_reg.gap != 16'h0000 && r_reg.count != 8'h00
			&& r_reg.idle_ms >= r_reg.gap) |=> MSG_RECOGNIZED)
		else $error("idle gap did not recognize");
	AST_BUF_LIMIT: assert property (
		r_reg.count <= 8'(BUF_BYTES))
		else $error("pending count above buffer size");
	AST_GAP_MIN: assert property (
		seq_gap_refused |=> r_reg.gap == $past(r_reg.gap))
		else $error("gap below minimum accepted");
	AST_CHANGE_ONLY_ON_RECOG: assert property (
		MSG_TEXT_CHANGED |-> MSG_RECOGNIZED && r_reg.l_valid)
		else $error("change event without recognition");
	AST_TRANSIENT_SET: assert property (
		MSG_RECOGNIZED |-> r_reg.t_valid && r_reg.t_ms == 8'h00
			&& r_reg.t_text == r_reg.l_text)
		else $error("transient copy not loaded");
	AST_CLEAR_ERASES: assert property (
		(REG_WR && REG_ADDR == ADDR_CTRL && REG_WDATA[CTRL_CLEAR])
			##1 !MSG_RECOGNIZED |-> !r_reg.l_valid && !r_reg.t_valid)
		else $error("clear left stored copies");
	AST_PULSE_SINGLE: assert property (
		MSG_RECOGNIZED |=> !MSG_RECOGNIZED)
		else $error("recognition pulse longer than one cycle");
	AST_INJ_STATUS: assert property (
		(REG_RD && REG_ADDR == ADDR_STATUS) |=>
			REG_RDATA[2] == $past(r_reg.inj_en && r_reg.op_sel == OP_INJECT))
		else $error("injection state misreported");
endmodule // smr_recognizer
`default_nettype wire

// ==== tb/smr_line_model.sv ====
// Serial equipment model: sends 8N1 frames to the block, decodes its output.
// Assumes the bench clock and a bit period of BIT_CYC clock cycles.
`default_nettype none
module smr_line_model
#(
	parameter int BIT_CYC = 8
)
(
	// Clock
	input  wire logic clk,
	// Line
	output logic      rxd,
	input  wire logic txd
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] last_tx;
	int         tx_count;

	// Idle line sits at mark level, as a real port does between frames
	initial
	begin
		rxd = 1'b1;
		last_tx = 8'h00;
		tx_count = 0;
	end

	// One frame: start bit, eight data bits LSB first, one stop bit
	task automatic send_byte(input logic [7:0] b);
		logic [9:0] f;
		f = {1'b1, b, 1'b0};
		for (int i = 0; i < 10; i++)
		begin
			@(posedge clk);
			rxd <= f[i];
			repeat (BIT_CYC - 1) @(posedge clk);
		end
	endtask

	// Sample mid-bit so a late edge on the pin cannot be mistaken
	initial
	begin
		logic [7:0] b;
		forever
		begin
			@(negedge txd);
			repeat (BIT_CYC / 2) @(posedge clk);
			for (int i = 0; i < 8; i++)
			begin
				repeat (BIT_CYC) @(posedge clk);
				b[i] = txd;
			end
			repeat (BIT_CYC) @(posedge clk);
			last_tx = b;
			tx_count++;
		end
	end
endmodule // smr_line_model
`default_nettype wire

// ==== tb/tb_smr_recognizer.sv ====
// Bench for the serial message recognizer: register tasks and line traffic.
// Assumes the line model and shortened tick and bit divisors.
`default_nettype none
module tb_smr_recognizer;
	timeunit 1ns;
	timeprecision 1ns;
	import smr_pkg::*;
	localparam int MSD = 10;
	localparam int BIT = 8;
	logic        clk;
	logic        arst_n;
	logic [7:0]  reg_addr;
	logic [31:0] reg_wdata;
	logic        reg_wr;
	logic        reg_rd;
	logic [31:0] reg_rdata;
	logic        ser_rxd;
	logic        ser_txd;
	logic        msg_rec;
	logic        msg_chg;
	int          fails;
	int          samples_checked;
	int          n_rec;
	int          n_chg;

	smr_recognizer #(.MS_DIV(MSD), .BAUD_DIV(BIT)) dut (.CLK(clk),
		.ARST_N(arst_n), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata),
		.REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA(reg_rdata),
		.SER_RXD(ser_rxd), .SER_TXD(ser_txd), .MSG_RECOGNIZED(msg_rec),
		.MSG_TEXT_CHANGED(msg_chg));
	smr_line_model #(.BIT_CYC(BIT)) line (.clk(clk), .rxd(ser_rxd),
		.txd(ser_txd));

	// 10 MHz clock
	initial
	begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	// Count event pulses on the falling edge, clear of register updates
	always @(negedge clk)
	begin
		if (msg_rec === 1'b1) n_rec++;
		if (msg_chg === 1'b1) n_chg++;
	end

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp)
		begin
			fails++;
			$display("ERROR %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= v;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask

	// Read data stand only in the cycle after the strobe
	task automatic rd(input logic [7:0] a, output logic [31:0] v);
		@(posedge clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1 v = reg_rdata;
	endtask

	task automatic rc(input logic [7:0] a, input logic [31:0] m, e);
		logic [31:0] v;
		rd(a, v);
		chk(v & m, e);
	endtask

	task automatic snd(input string s);
		for (int i = 0; i < s.len(); i++)
			line.send_byte(s[i]);
		repeat (10) @(posedge clk);
	endtask

	// Poll ready; a write while busy would be dropped
	task automatic txr;
		logic [31:0] v;
		v = 32'h0;
		repeat (2) @(posedge clk);
		for (int k = 0; k < 300 && v[3] !== 1'b1; k++)
			rd(ADDR_STATUS, v);
	endtask

	task automatic txs(input logic [1:0] m, input string s);
		for (int i = 0; i < s.len(); i++)
		begin
			txr;
			wr(ADDR_TX, {22'h0, m, s[i]});
		end
		txr;
		// Ready only means the byte was handed over; let the frame finish
		repeat (12 * BIT) @(posedge clk);
	endtask

	task automatic stop_test;
		$display("checks %0d mismatches %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	// Cut a hang short; the tests need well under 10000 cycles
	initial
	begin
		#2_000_000;
		fails++;
		$display("ERROR %0t watchdog expired", $time);
		stop_test;
	end

	// Test sequence
	initial
	begin
		{fails, samples_checked, n_rec, n_chg} = '0;
		{arst_n, reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
		repeat (2) @(posedge clk);
		arst_n <= 1'b1;
		rc(ADDR_HOLD, 32'hFF, 32'h32);
		wr(ADDR_GAP, 32'h5);
		rc(ADDR_GAP, 32'hFFFF, 32'h0);
		rc(8'hFC, '1, 32'h0);
		$display("test reset done");
		wr(ADDR_DLM_LO, 32'h3A);
		wr(ADDR_DLM_LEN, 32'h1);
		wr(ADDR_CTRL, 32'h1);
		snd("Lo:");
		chk(n_rec, 1);
		chk(n_chg, 1);
		rc(ADDR_STATUS, 32'h00FFFF0F, 32'h0003000B);
		rc(ADDR_LTEXT, '1, 32'h003A6F4C);
		rc(ADDR_LHEX, '1, 32'h46364334);
		rc(ADDR_TTEXT, '1, 32'h003A6F4C);
		rc(ADDR_DIGEST, 32'hFFFF, 32'h1919);
		$display("test delimiter done");
		wr(ADDR_HOLD, 32'h2);
		snd("Lo:");
		chk(n_rec, 2);
		chk(n_chg, 1);
		repeat (4 * MSD) @(posedge clk);
		rc(ADDR_STATUS, 32'h3, 32'h1);
		rc(ADDR_TTEXT, '1, 32'h0);
		rc(ADDR_LTEXT, '1, 32'h003A6F4C);
		snd("0123456789AB:");
		rc(8'h48, '1, 32'h42413938);
		rc(ADDR_STATUS, 32'h00FF0000, 32'h000D0000);
		$display("test hold done");
		wr(ADDR_CTRL, 32'h11);
		rc(ADDR_STATUS, 32'h3, 32'h0);
		rc(ADDR_LTEXT, '1, 32'h0);
		$display("test clear done");
		wr(ADDR_GAP, 32'hA);
		rc(ADDR_GAP, 32'hFFFF, 32'hA);
		snd("AB");
		chk(n_rec, 3);
		repeat (11 * MSD) @(posedge clk);
		chk(n_rec, 4);
		rc(ADDR_LTEXT, '1, 32'h4241);
		rc(ADDR_DIGEST, 32'hFF, 32'h03);
		$display("test gap done");
		wr(ADDR_GAP, 32'h0);
		wr(ADDR_CTRL, 32'h0);
		snd("Z");
		rc(ADDR_STATUS, 32'hFF00, 32'h0);
		wr(ADDR_CTRL, 32'h1);
		snd("Z");
		rc(ADDR_STATUS, 32'hFF00, 32'h100);
		wr(ADDR_GAP, 32'hA);
		repeat (12 * MSD) @(posedge clk);
		chk(n_rec, 5);
		rc(ADDR_LTEXT, '1, 32'h5A);
		$display("test pending done");
		wr(ADDR_DLM_LO, 32'h0D0A);
		wr(ADDR_DLM_LEN, 32'h2);
		wr(ADDR_DLM_LEN, 32'h9);
		rc(ADDR_DLM_LEN, 32'hF, 32'h2);
		// Lone LF and doubled CR must not match a two-byte pattern
		line.send_byte(8'h0A);
		line.send_byte(8'h0D);
		line.send_byte(8'h0D);
		line.send_byte(8'h0A);
		repeat (10) @(posedge clk);
		chk(n_rec, 6);
		rc(ADDR_LTEXT, '1, 32'h0A0D0D0A);
		rc(ADDR_STATUS, 32'h00FF0000, 32'h00040000);
		$display("test delimiter pair done");
		wr(ADDR_CTRL, 32'hA);
		rc(ADDR_STATUS, 32'h4, 32'h4);
		wr(ADDR_CTRL, 32'h2);
		rc(ADDR_STATUS, 32'h4, 32'h0);
		$display("test injection done");
		txs(TXM_ESC, "\\x0D");
		chk({24'h0, line.last_tx}, 32'h0D);
		chk(line.tx_count, 1);
		txs(TXM_HEX, "41");
		chk({24'h0, line.last_tx}, 32'h41);
		txs(TXM_RAW, "\\");
		chk({24'h0, line.last_tx}, 32'h5C);
		chk(line.tx_count, 3);
		$display("test transmit done");
		stop_test;
	end
endmodule // tb_smr_recognizer
`default_nettype wire
